// ==== rtl/bsc_defines.svh ====
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define BSC_OFF_INSTR      12'h000
`define BSC_OFF_STATUS     12'h004
`define BSC_OFF_ACC        12'h008
`define BSC_OFF_PC         12'h00c
`define BSC_OFF_LATCH      12'h010
`define BSC_OFF_WDOG       12'h014
`define BSC_OFF_STACK      12'h018
`define BSC_RF_SEL         3'h2
`define BSC_FLD_RF_SEL     11:9
`define BSC_FLD_RF_IDX     8:2

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define BSC_FLD_OP         3:0
`define BSC_BIT_DEST       4
`define BSC_FLD_BIT        7:5
`define BSC_FLD_FILE       14:8
`define BSC_FLD_LIT        26:16
`define BSC_INSTR_W        27

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define BSC_OP_NOP         4'h0
`define BSC_OP_SKIP_SET    4'h1
`define BSC_OP_WDOG_CLR    4'h2
`define BSC_OP_CALL        4'h3
`define BSC_OP_COMPL       4'h4
`define BSC_OP_REG_ZERO    4'h5
`define BSC_OP_DECR        4'h6
`define BSC_OP_ACC_CLR     4'h7

// ----------------------------------------------------------------
// STATUS bits, upper latch bits, widths and reset values
// ----------------------------------------------------------------
`define BSC_ST_ZERO        0
`define BSC_ST_PD_N        1
`define BSC_ST_TO_N        2
`define BSC_ST_BUSY        3
`define BSC_ST_SKIP        4
`define BSC_FLD_LATCH_UP   4:3
`define BSC_PC_W           13
`define BSC_LATCH_W        5
`define BSC_SP_W           3
`define BSC_STACK_DEPTH    8
`define BSC_RF_DEPTH       128
`define BSC_BYTE_ZERO      8'h00
`define BSC_BYTE_ONE       8'h01
`define BSC_BYTE_MAX       8'hff
`define BSC_PC_ZERO        13'h0000
`define BSC_PC_ONE         13'h0001
`define BSC_LATCH_ZERO     5'h00
`define BSC_SP_ZERO        3'h0
`define BSC_SP_ONE         3'h1
`define BSC_WORD_ZERO      32'h0000_0000
`define BSC_INSTR_ZERO     27'h000_0000

`endif

// ==== rtl/bsc_pkg.sv ====
package bsc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SECOND
  } bsc_state_t;
endpackage

// ==== rtl/bsc_regfile.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defines.svh"

module bsc_regfile (
  // Clock
  input  wire logic       i_clk,
  // Write port
  input  wire logic       i_we,
  input  wire logic [6:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  // Read port
  input  wire logic [6:0] i_raddr,
  output logic      [7:0] o_rdata
);

  // No reset: file contents are undefined until written, as in the device
  logic [7:0] mem [`BSC_RF_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];

endmodule

`default_nettype wire

// ==== rtl/bsc_core.sv ====
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defines.svh"

// Behaviour
// - Skip-if-bit-set with bit 1 discards next instruction, runs a no-op instead.
// - Skip-if-bit-set with bit 0 runs next instruction normally, flags untouched.
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets the power-down flag to one, and the timeout flag too unless a timeout lands in that cycle.
// - Call pushes program counter plus one onto the return stack.
// - Call loads its eleven-bit literal into program counter bits 10 to 0.
// - Call copies upper latch bits 4 and 3 into counter bits 12 and 11.
// - Call takes two cycles and leaves all status flags alone.
// - Complement inverts the register, result to accumulator or register, updates zero.
// - Register clear writes zero to the addressed register and sets zero flag.
// - Decrement subtracts one, result to accumulator or register, updates zero.
// - Accumulator clear zeroes the accumulator and sets the zero flag.
// - Only a call costs a second no-op cycle; a true test costs none and discards the next issued word.
module bsc_core
  import bsc_pkg::*;
(
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_NRST,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bsc_state_t                 state;
  logic [`BSC_INSTR_W-1:0]    instr;
  logic [7:0]                 acc;
  logic                       zero_flag;
  logic                       timeout_flag_n;
  logic                       powerdown_flag_n;
  logic                       skip_pending;
  logic [`BSC_PC_W-1:0]       pc;
  logic [`BSC_LATCH_W-1:0]    upper_address_latch;
  logic [`BSC_SP_W-1:0]       sp;
  // Return stack: no overflow or underflow is reported
  logic [`BSC_PC_W-1:0]       stack [`BSC_STACK_DEPTH];
  logic [7:0]                 watchdog_counter;
  logic [7:0]                 wdog_prescaler;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `BSC_BYTE_ZERO);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire       access     = I_PSEL & I_PENABLE;
  // Bus writes land only on the completing edge, which is always an idle cycle
  wire       apb_fire   = access & O_PREADY;
  wire       apb_wr     = apb_fire & I_PWRITE;
  wire       rf_hit     = (I_PADDR[`BSC_FLD_RF_SEL] == `BSC_RF_SEL);
  wire [6:0] rf_idx     = I_PADDR[`BSC_FLD_RF_IDX];
  wire       hit_instr  = (I_PADDR == `BSC_OFF_INSTR);
  wire       hit_status = (I_PADDR == `BSC_OFF_STATUS);
  wire       hit_acc    = (I_PADDR == `BSC_OFF_ACC);
  wire       hit_pc     = (I_PADDR == `BSC_OFF_PC);
  wire       hit_latch  = (I_PADDR == `BSC_OFF_LATCH);
  wire       hit_wdog   = (I_PADDR == `BSC_OFF_WDOG);
  wire       hit_stack  = (I_PADDR == `BSC_OFF_STACK);
  wire       mapped     = rf_hit | hit_instr | hit_status | hit_acc | hit_pc | hit_latch
                          | hit_wdog | hit_stack;
  // Read-only registers refuse writes, write-only instruction port refuses reads
  wire       refused    = !mapped | (I_PWRITE & (hit_status | hit_wdog | hit_stack))
                          | (!I_PWRITE & hit_instr);
  wire       issue      = apb_wr & hit_instr & !refused;
  wire       idle       = (state == ST_IDLE);
  // Ready is registered, so every access phase has at least one wait state
  // Stall the access phase while an instruction runs, so bus and core never collide
  wire       next_pready = access & !O_PREADY & idle;

  // ----------------------------------------------------------------
  // Execute decode
  // ----------------------------------------------------------------
  wire [3:0]  op_raw   = instr[`BSC_FLD_OP];
  wire        in_exec  = (state == ST_EXEC);
  // A pending skip turns whatever arrives next into a one-cycle no-op
  wire [3:0]  op       = skip_pending ? `BSC_OP_NOP : op_raw;
  wire        dest_reg = instr[`BSC_BIT_DEST];
  wire [2:0]  bit_sel  = instr[`BSC_FLD_BIT];
  wire [6:0]  file_sel = instr[`BSC_FLD_FILE];
  wire [10:0] literal  = instr[`BSC_FLD_LIT];
  wire [7:0]  rf_rdata;
  wire [6:0]  rf_raddr = in_exec ? file_sel : rf_idx;

  wire        do_skip  = in_exec & (op == `BSC_OP_SKIP_SET);
  // Unwritten file registers read unknown; software must seed them first
  wire        bit_true = rf_rdata[bit_sel];
  wire        do_wclr  = in_exec & (op == `BSC_OP_WDOG_CLR);
  wire        do_call  = in_exec & (op == `BSC_OP_CALL);
  wire        do_comp  = in_exec & (op == `BSC_OP_COMPL);
  wire        do_rzero = in_exec & (op == `BSC_OP_REG_ZERO);
  wire        do_dec   = in_exec & (op == `BSC_OP_DECR);
  wire        do_aclr  = in_exec & (op == `BSC_OP_ACC_CLR);

  wire [7:0]  res_comp = ~rf_rdata;
  wire [7:0]  res_dec  = rf_rdata - `BSC_BYTE_ONE;
  wire [7:0]  result   = do_comp ? res_comp : res_dec;
  wire        alu_op   = do_comp | do_dec;

  // Register file write: core first, APB only while idle
  wire        core_rf_we = (alu_op & dest_reg) | do_rzero;
  wire        apb_rf_we  = apb_wr & rf_hit;
  wire        rf_we      = core_rf_we | apb_rf_we;
  wire [6:0]  rf_waddr   = in_exec ? file_sel : rf_idx;
  wire [7:0]  rf_wdata   = in_exec ? (do_rzero ? `BSC_BYTE_ZERO : result) : I_PWDATA[7:0];

  wire [`BSC_PC_W-1:0] pc_plus1    = pc + `BSC_PC_ONE;
  // Only latch bits 4 and 3 reach the counter; the lower latch bits are ignored
  wire [`BSC_PC_W-1:0] call_target = {upper_address_latch[`BSC_FLD_LATCH_UP], literal};

  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  wire [31:0] status_word = {27'h000_0000, skip_pending, !idle, timeout_flag_n,
                             powerdown_flag_n, zero_flag};
  // Stack word shows the entry just pushed; with the pointer at zero the
  // last slot, index 7, is shown, which may never have been written
  wire [31:0] rd_word =
    rf_hit     ? {24'h00_0000, rf_rdata} :
    hit_status ? status_word :
    hit_acc    ? {24'h00_0000, acc} :
    hit_pc     ? {19'h0_0000, pc} :
    hit_latch  ? {27'h000_0000, upper_address_latch} :
    hit_wdog   ? {16'h0000, wdog_prescaler, watchdog_counter} :
    hit_stack  ? {13'h0000, sp, 3'h0, stack[sp - `BSC_SP_ONE]} :
                 `BSC_WORD_ZERO;

  // Refusal and read data are judged in the cycle that raises ready, so
  // they always belong to the transfer that completes on the next edge
  wire        next_pslverr = next_pready & refused;
  wire [31:0] next_prdata  = (next_pready & !I_PWRITE & !refused) ? rd_word : `BSC_WORD_ZERO;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= `BSC_WORD_ZERO;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= next_pready;
      O_PSLVERR <= next_pslverr;
      O_PRDATA  <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  bsc_state_t next_state;

  // The second cycle of a call is the no-op; only the watchdog prescaler, counter and timeout flag are updated in it
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   next_state = issue ? ST_EXEC : ST_IDLE;
      ST_EXEC:   next_state = do_call ? ST_SECOND : ST_IDLE;
      ST_SECOND: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
      instr <= `BSC_INSTR_ZERO;
    end else begin
      state <= next_state;
      if (issue) begin
        instr <= I_PWDATA[`BSC_INSTR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Skip, accumulator and zero flag
  // ----------------------------------------------------------------
  // Skip state is only re-evaluated while an instruction executes
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      skip_pending <= 1'b0;
    end else if (in_exec) begin
      // Discarded instruction is consumed as a one-cycle no-op
      skip_pending <= do_skip & bit_true;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      acc       <= `BSC_BYTE_ZERO;
      zero_flag <= 1'b0;
    end else if (do_aclr) begin
      acc       <= `BSC_BYTE_ZERO;
      zero_flag <= 1'b1;
    end else if (do_rzero) begin
      // Register clear leaves the accumulator as it is
      zero_flag <= 1'b1;
    end else if (alu_op) begin
      if (!dest_reg) begin
        acc <= result;
      end
      zero_flag <= is_zero(result);
    end else if (apb_wr & hit_acc) begin
      acc <= I_PWDATA[7:0];
    end
  end

  // Core and bus never write in the same cycle: the bus stalls while busy
  bsc_regfile u_regfile (
    .i_clk   (I_REF_CLK),
    .i_we    (rf_we),
    .i_waddr (rf_waddr),
    .i_wdata (rf_wdata),
    .i_raddr (rf_raddr),
    .o_rdata (rf_rdata)
  );

  // ----------------------------------------------------------------
  // Program counter, upper latch and return stack
  // ----------------------------------------------------------------
  // Every executed word, skipped ones included, advances the counter;
  // a call replaces that step with its target
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pc                  <= `BSC_PC_ZERO;
      upper_address_latch <= `BSC_LATCH_ZERO;
      sp                  <= `BSC_SP_ZERO;
    end else if (do_call) begin
      pc <= call_target;
      sp <= sp + `BSC_SP_ONE;
    end else if (in_exec) begin
      pc <= pc_plus1;
    end else if (apb_wr & hit_pc) begin
      pc <= I_PWDATA[`BSC_PC_W-1:0];
    end else if (apb_wr & hit_latch) begin
      upper_address_latch <= I_PWDATA[`BSC_LATCH_W-1:0];
    end
  end

  // Circular stack: a ninth push silently overwrites the oldest entry
  always_ff @(posedge I_REF_CLK) begin
    if (do_call) begin
      stack[sp] <= pc_plus1;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Eight-bit prescaler feeding an eight-bit counter: one timeout every
  // 65536 clocks, and the count keeps wrapping after it
  wire pre_wrap  = (wdog_prescaler == `BSC_BYTE_MAX);
  wire wdog_trip = pre_wrap & (watchdog_counter == `BSC_BYTE_MAX);

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      watchdog_counter <= `BSC_BYTE_ZERO;
      wdog_prescaler   <= `BSC_BYTE_ZERO;
    end else if (do_wclr) begin
      watchdog_counter <= `BSC_BYTE_ZERO;
      wdog_prescaler   <= `BSC_BYTE_ZERO;
    end else begin
      wdog_prescaler <= wdog_prescaler + `BSC_BYTE_ONE;
      if (pre_wrap) begin
        watchdog_counter <= watchdog_counter + `BSC_BYTE_ONE;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      // Timeout event wins over a clear in the same cycle
      if (wdog_trip) begin
        timeout_flag_n <= 1'b0;
      end else if (do_wclr) begin
        timeout_flag_n <= 1'b1;
      end
      // No sleep state here, so the power-down flag only ever gets set
      if (do_wclr) begin
        powerdown_flag_n <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== test/bsc_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defines.svh"
module bsc_chk (
  // Clock and reset
  input wire logic        I_REF_CLK,
  input wire logic        I_NRST,
  // Bus
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);
  sequence s_setup;
    I_PSEL && !I_PENABLE;
  endsequence
  // Set after a skip was issued, whose successor may be discarded
  logic after_skip;
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      after_skip <= 1'b0;
    end else if (O_PREADY && I_PWRITE && !O_PSLVERR && I_PADDR == `BSC_OFF_INSTR) begin
      after_skip <= (I_PWDATA[`BSC_FLD_OP] == `BSC_OP_SKIP_SET);
    end
  end
  sequence s_access;
    I_PSEL && I_PENABLE;
  endsequence
  sequence s_chain;
    s_setup ##1 s_access;
  endsequence
  sequence s_call_done;
    O_PREADY && I_PWRITE && !O_PSLVERR && I_PADDR == `BSC_OFF_INSTR
      && I_PWDATA[`BSC_FLD_OP] == `BSC_OP_CALL && !after_skip;
  endsequence
  sequence s_short_done;
    O_PREADY && I_PWRITE && !O_PSLVERR && I_PADDR == `BSC_OFF_INSTR
      && (I_PWDATA[`BSC_FLD_OP] != `BSC_OP_CALL || after_skip);
  endsequence
  sequence s_call_gap;
    !O_PREADY ##1 O_PREADY;
  endsequence
  a_ready_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("ready outside access");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_wait_state: assert property (s_setup |=> !O_PREADY)
    else $error("no wait state");
  a_answer_bound: assert property (s_setup ##1 I_PENABLE |-> ##[0:3] O_PREADY)
    else $error("answer too late");
  a_idle_data: assert property (!O_PREADY |-> O_PRDATA == `BSC_WORD_ZERO)
    else $error("read data outside answer");
  a_err_data: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == `BSC_WORD_ZERO)
    else $error("bad error answer");
  a_instr_read: assert property (O_PREADY && !I_PWRITE && I_PADDR == `BSC_OFF_INSTR |-> O_PSLVERR)
    else $error("instruction read not refused");
  a_file_ok: assert property (O_PREADY && I_PADDR[`BSC_FLD_RF_SEL] == `BSC_RF_SEL |-> !O_PSLVERR)
    else $error("file access refused");
  a_call_stall: assert property (s_call_done ##1 s_chain |=> s_call_gap)
    else $error("call stall not exactly one extra cycle");
  a_op_single: assert property (s_short_done ##1 s_chain |=> O_PREADY)
    else $error("single-cycle instruction stalled the bus");
endmodule
bind bsc_core bsc_chk u_chk (
  .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR));
`default_nettype wire

// ==== test/test_bit_skip_clear_call_exec.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bsc_defines.svh"
module test_bit_skip_clear_call_exec;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] r;
  logic        e;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  bsc_core uut (.I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task finish_test;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog wait dominates the run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Called just after an edge; transfers chain back to back, rel ends a run
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk({31'h0, e}, {31'h0, ee});
  endtask

  task rel;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 1'b0);
    chk(r, exp);
  endtask

  task ex(input logic [3:0] op, input logic d, input logic [2:0] b, input logic [6:0] f,
          input logic [10:0] k);
    xfer(1'b1, `BSC_OFF_INSTR, {5'h00, k, 1'b0, f, b, d, op}, 1'b0);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] f);
    return {`BSC_RF_SEL, f, 2'b00};
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`BSC_OFF_STATUS, 32'h6);
    xfer(1'b1, fa(7'h7f), 32'h5a, 1'b0);
    ex(`BSC_OP_REG_ZERO, 1'b0, 3'h0, 7'h7f, 11'h000);
    rd(fa(7'h7f), 32'h0);
    rd(`BSC_OFF_STATUS, 32'h7);
    xfer(1'b1, fa(7'h03), 32'h0f, 1'b0);
    ex(`BSC_OP_COMPL, 1'b0, 3'h0, 7'h03, 11'h000);
    rd(`BSC_OFF_ACC, 32'hf0);
    rd(fa(7'h03), 32'h0f);
    rd(`BSC_OFF_STATUS, 32'h6);
    xfer(1'b1, fa(7'h04), 32'hff, 1'b0);
    ex(`BSC_OP_COMPL, 1'b1, 3'h0, 7'h04, 11'h000);
    rd(fa(7'h04), 32'h0);
    rd(`BSC_OFF_STATUS, 32'h7);
    xfer(1'b1, fa(7'h05), 32'h01, 1'b0);
    ex(`BSC_OP_DECR, 1'b1, 3'h0, 7'h05, 11'h000);
    rd(fa(7'h05), 32'h0);
    ex(`BSC_OP_DECR, 1'b0, 3'h0, 7'h05, 11'h000);
    rd(`BSC_OFF_ACC, 32'hff);
    rd(`BSC_OFF_STATUS, 32'h6);
    ex(`BSC_OP_ACC_CLR, 1'b0, 3'h0, 7'h00, 11'h000);
    rd(`BSC_OFF_ACC, 32'h0);
    rd(`BSC_OFF_STATUS, 32'h7);
    xfer(1'b1, `BSC_OFF_PC, 32'h0100, 1'b0);
    xfer(1'b1, `BSC_OFF_LATCH, 32'h13, 1'b0);
    ex(`BSC_OP_CALL, 1'b0, 3'h0, 7'h00, 11'h7ff);
    rd(`BSC_OFF_PC, 32'h17ff);
    rd(`BSC_OFF_STACK, 32'h0001_0101);
    rd(`BSC_OFF_STATUS, 32'h7);
    xfer(1'b1, `BSC_OFF_PC, 32'h0010, 1'b0);
    xfer(1'b1, fa(7'h0a), 32'h80, 1'b0);
    ex(`BSC_OP_SKIP_SET, 1'b0, 3'h7, 7'h0a, 11'h000);
    rd(`BSC_OFF_STATUS, 32'h17);
    ex(`BSC_OP_DECR, 1'b0, 3'h0, 7'h0a, 11'h000);
    rd(`BSC_OFF_ACC, 32'h0);
    rd(`BSC_OFF_PC, 32'h0012);
    ex(`BSC_OP_SKIP_SET, 1'b0, 3'h6, 7'h0a, 11'h000);
    rd(`BSC_OFF_STATUS, 32'h7);
    ex(`BSC_OP_DECR, 1'b0, 3'h0, 7'h0a, 11'h000);
    rd(`BSC_OFF_ACC, 32'h7f);
    rd(`BSC_OFF_PC, 32'h0014);
    ex(`BSC_OP_NOP, 1'b0, 3'h0, 7'h00, 11'h000);
    ex(4'hf, 1'b0, 3'h0, 7'h00, 11'h000);
    rd(`BSC_OFF_PC, 32'h0016);
    xfer(1'b0, 12'h800, 32'h0, 1'b1);
    xfer(1'b1, `BSC_OFF_STATUS, 32'h0, 1'b1);
    xfer(1'b0, `BSC_OFF_INSTR, 32'h0, 1'b1);
    rel();
    // Let the watchdog run out so the clear has a flag to restore
    repeat (65600) @(posedge clk);
    rd(`BSC_OFF_STATUS, 32'h2);
    ex(`BSC_OP_WDOG_CLR, 1'b0, 3'h0, 7'h00, 11'h000);
    xfer(1'b0, `BSC_OFF_WDOG, 32'h0, 1'b0);
    chk({24'h0, r[7:0]}, 32'h0);
    chk({24'h0, r[15:8]}, 32'h0);
    rd(`BSC_OFF_STATUS, 32'h6);
    finish_test();
  end
endmodule
`default_nettype wire
